// ===== src/dio_ctrl.sv
// four-line digital io control with register port
`default_nettype none
`include "dio_defs.svh"
module dio_ctrl
    import dio_pkg::*;
#(
    parameter int NLINE = 4,
    parameter int NUSER = 4,
    parameter int SPAN_W = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdData,
    // connector lines, open drain: oe low while driving low
    input wire logic [NLINE-1:0] lineIn,
    output logic [NLINE-1:0] lineOut,
    output logic [NLINE-1:0] lineOeN,
    output logic [NLINE-1:0] auxRailOn,
    // internal drive sources
    input wire logic [1:0] counterActive,
    input wire logic [1:0] logicBlockOut,
    input wire logic exposureActive,
    input wire logic frameTriggerWait,
    input wire logic ppsSignal,
    input wire logic serialTx,
    // user output bank for internal use
    output logic [NUSER-1:0] swBits
);
    // ---------------------------------------------
    // configuration state
    // ---------------------------------------------
    logic [1:0] linePick_r, linePick_nxt;
    logic [NLINE-1:0] direction_r, direction_nxt;
    logic [NLINE-1:0] polarity_r, polarity_nxt;
    logic [NLINE-1:0] auxRail_r, auxRail_nxt;
    logic filterKind_r, filterKind_nxt;
    logic [SPAN_W-1:0] glitchSpan_r [NLINE];
    logic [SPAN_W-1:0] glitchSpan_nxt [NLINE];
    logic [SPAN_W-1:0] bounceSpan_r [NLINE];
    logic [SPAN_W-1:0] bounceSpan_nxt [NLINE];
    logic [4:0] source_r [NLINE];
    logic [4:0] source_nxt [NLINE];
    logic [1:0] swPick_r, swPick_nxt;
    logic [NUSER-1:0] swBits_r, swBits_nxt;
    logic [31:0] rdData_r, rdData_nxt;
    logic [NLINE-1:0] drvLevel_r, drvLevel_nxt;
    logic [NLINE-1:0] oeN_r, oeN_nxt;

    // ---------------------------------------------
    // pin synchronisers and filters
    // ---------------------------------------------
    logic [NLINE-1:0] pinMeta_r;
    logic [NLINE-1:0] pinSync_r;
    logic [NLINE-1:0] filtered;
    logic [NLINE-1:0] level;

    always_ff @(posedge mclk) begin
        // reset to the pull-up level, so the filters see no false
        // edge when reset lets go
        if (sys_rst) begin
            pinMeta_r <= '1;
            pinSync_r <= '1;
        end else begin
            pinMeta_r <= lineIn;
            pinSync_r <= pinMeta_r;
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < NLINE; gi++) begin : g_line
            dio_line_filter #(
                .SPAN_W(SPAN_W)
            ) u_filter (
                .mclk(mclk),
                .sys_rst(sys_rst),
                .rawLevel(pinSync_r[gi]),
                .glitchSpanUs(glitchSpan_r[gi]),
                .bounceSpanUs(bounceSpan_r[gi]),
                .cleanLevel(filtered[gi])
            );
            // flip applies on the input side
            // output lines report their driven level
            assign level[gi] = direction_r[gi] ? drvLevel_r[gi]
                                               : filtered[gi] ^ polarity_r[gi];
        end
    endgenerate

    // ---------------------------------------------
    // source mux
    // ---------------------------------------------
    function automatic logic pickSource(input logic [4:0] sel,
                                        input logic [NLINE-1:0] lv,
                                        input logic [NUSER-1:0] ub);
        logic r;
        r = 1'b0;
        case (sel)
            DIO_SRC_LINE0: r = lv[0];
            DIO_SRC_LINE1: r = lv[1];
            DIO_SRC_LINE2: r = lv[2];
            DIO_SRC_LINE3: r = lv[3];
            DIO_SRC_USER0: r = ub[0];
            DIO_SRC_USER1: r = ub[1];
            DIO_SRC_USER2: r = ub[2];
            DIO_SRC_USER3: r = ub[3];
            DIO_SRC_CNT0: r = counterActive[0];
            DIO_SRC_CNT1: r = counterActive[1];
            DIO_SRC_LOGIC0: r = logicBlockOut[0];
            DIO_SRC_LOGIC1: r = logicBlockOut[1];
            DIO_SRC_EXPOSE: r = exposureActive;
            DIO_SRC_TRIGWAIT: r = frameTriggerWait;
            DIO_SRC_PPS: r = ppsSignal;
            DIO_SRC_SERIAL: r = serialTx;
            default: r = 1'b0;
        endcase
        return r;
    endfunction

    // ---------------------------------------------
    // register write
    // ---------------------------------------------
    logic [7:0] circuitCodes;
    logic [NLINE-1:0] auxCapable;
    logic srcLevel;
    assign circuitCodes = `DIO_CIRCUIT_CODES;
    assign auxCapable = NLINE'(`DIO_AUX_CAPABLE);

    always_comb begin
        logic [1:0] lp;
        lp = linePick_r;
        linePick_nxt = linePick_r;
        direction_nxt = direction_r;
        polarity_nxt = polarity_r;
        auxRail_nxt = auxRail_r;
        filterKind_nxt = filterKind_r;
        glitchSpan_nxt = glitchSpan_r;
        bounceSpan_nxt = bounceSpan_r;
        source_nxt = source_r;
        swPick_nxt = swPick_r;
        swBits_nxt = swBits_r;
        // writes land at the next edge, in time for a following read
        if (regWrStb) begin
            case (regAddr)
                `DIO_OFS_LINE_PICK: linePick_nxt = regWrData[1:0];
                `DIO_OFS_LINE_DIRECTION: direction_nxt[lp] = regWrData[0];
                // only capable lines keep the switch
                `DIO_OFS_AUX_RAIL:
                    auxRail_nxt[lp] = regWrData[0] & auxCapable[lp];
                `DIO_OFS_POLARITY: polarity_nxt[lp] = regWrData[0];
                `DIO_OFS_FILTER_KIND: filterKind_nxt = regWrData[0];
                `DIO_OFS_FILTER_SPAN: begin
                    if (filterKind_r) begin
                        bounceSpan_nxt[lp] = regWrData[SPAN_W-1:0];
                    end else begin
                        glitchSpan_nxt[lp] = regWrData[SPAN_W-1:0];
                    end
                end
                `DIO_OFS_DRIVE_SOURCE: source_nxt[lp] = regWrData[4:0];
                `DIO_OFS_SW_BIT_PICK: swPick_nxt = regWrData[1:0];
                `DIO_OFS_SW_BIT_LEVEL: swBits_nxt[swPick_r] = regWrData[0];
                `DIO_OFS_SW_BITS: swBits_nxt = regWrData[NUSER-1:0];
                // circuit type and unmapped writes ignored
                default: linePick_nxt = linePick_r;
            endcase
        end
    end

    // ---------------------------------------------
    // read data
    // ---------------------------------------------
    // the answer is registered, so it stands for exactly one cycle
    // and reads as zero otherwise
    always_comb begin
        logic [1:0] lp;
        lp = linePick_r;
        rdData_nxt = '0;
        if (regRdStb) begin
            case (regAddr)
                `DIO_OFS_LINE_PICK: rdData_nxt[1:0] = linePick_r;
                `DIO_OFS_LINE_DIRECTION: rdData_nxt[0] = direction_r[lp];
                `DIO_OFS_AUX_RAIL: rdData_nxt[0] = auxRail_r[lp];
                `DIO_OFS_POLARITY: rdData_nxt[0] = polarity_r[lp];
                `DIO_OFS_PIN_LEVEL: rdData_nxt[0] = level[lp];
                `DIO_OFS_PIN_LEVELS: rdData_nxt[NLINE-1:0] = level;
                `DIO_OFS_FILTER_KIND: rdData_nxt[0] = filterKind_r;
                `DIO_OFS_FILTER_SPAN:
                    rdData_nxt[SPAN_W-1:0] = filterKind_r ? bounceSpan_r[lp]
                                                          : glitchSpan_r[lp];
                `DIO_OFS_DRIVE_SOURCE: rdData_nxt[4:0] = source_r[lp];
                `DIO_OFS_CIRCUIT_TYPE:
                    rdData_nxt[1:0] = circuitCodes[2*lp +: 2];
                `DIO_OFS_SW_BIT_PICK: rdData_nxt[1:0] = swPick_r;
                `DIO_OFS_SW_BIT_LEVEL: rdData_nxt[0] = swBits_r[swPick_r];
                `DIO_OFS_SW_BITS: rdData_nxt[NUSER-1:0] = swBits_r;
                default: rdData_nxt = '0;
            endcase
        end
    end

    // ---------------------------------------------
    // pin drive
    // ---------------------------------------------
    // sources are read from registered levels, so a loopback line
    // follows its partner one cycle later than the partner's level
    always_comb begin
        srcLevel = 1'b0;
        drvLevel_nxt = drvLevel_r;
        oeN_nxt = '1;
        // an output line with its source off pulls low unless its polarity is flipped
        for (int i = 0; i < NLINE; i++) begin
            srcLevel = pickSource(source_r[i], level, swBits_r);
            // flip applies on the output side
            drvLevel_nxt[i] = srcLevel ^ polarity_r[i];
            // drive only while direction is output
            oeN_nxt[i] = !(direction_r[i] && !drvLevel_nxt[i]);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            linePick_r <= '0;
            direction_r <= '0;
            polarity_r <= '0;
            auxRail_r <= '0;
            filterKind_r <= 1'b0;
            for (int i = 0; i < NLINE; i++) begin
                glitchSpan_r[i] <= `DIO_SPAN_RST;
                bounceSpan_r[i] <= `DIO_SPAN_RST;
                source_r[i] <= `DIO_SRC_RST;
            end
            swPick_r <= '0;
            swBits_r <= '0;
        end else begin
            linePick_r <= linePick_nxt;
            direction_r <= direction_nxt;
            polarity_r <= polarity_nxt;
            auxRail_r <= auxRail_nxt;
            filterKind_r <= filterKind_nxt;
            glitchSpan_r <= glitchSpan_nxt;
            bounceSpan_r <= bounceSpan_nxt;
            source_r <= source_nxt;
            swPick_r <= swPick_nxt;
            swBits_r <= swBits_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData_r <= '0;
        end else begin
            rdData_r <= rdData_nxt;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            drvLevel_r <= '0;
            oeN_r <= '1;
        end else begin
            drvLevel_r <= drvLevel_nxt;
            oeN_r <= oeN_nxt;
        end
    end

    // open drain: the pin only ever pulls low
    assign regRdData = rdData_r;
    assign lineOut = '0;
    assign lineOeN = oeN_r;
    assign auxRailOn = auxRail_r;
    assign swBits = swBits_r;
endmodule // dio_ctrl
`default_nettype wire

// ===== src/dio_defs.svh
// constants and register map of the four-line digital io control block
`ifndef DIO_DEFS_SVH
`define DIO_DEFS_SVH

// ---------------------------------------------
// register offsets (byte addresses)
// ---------------------------------------------
`define DIO_OFS_LINE_PICK 8'h00
`define DIO_OFS_LINE_DIRECTION 8'h04
`define DIO_OFS_AUX_RAIL 8'h08
`define DIO_OFS_POLARITY 8'h0c
`define DIO_OFS_PIN_LEVEL 8'h10
`define DIO_OFS_PIN_LEVELS 8'h14
`define DIO_OFS_FILTER_KIND 8'h18
`define DIO_OFS_FILTER_SPAN 8'h1c
`define DIO_OFS_DRIVE_SOURCE 8'h20
`define DIO_OFS_CIRCUIT_TYPE 8'h24
`define DIO_OFS_SW_BIT_PICK 8'h28
`define DIO_OFS_SW_BIT_LEVEL 8'h2c
`define DIO_OFS_SW_BITS 8'h30

// ---------------------------------------------
// timing and reset values
// ---------------------------------------------
`define DIO_CLK_MHZ 250
`define DIO_SPAN_RST 16'h0000
`define DIO_SRC_RST 5'h00
// one bit per line, set for an aux-rail capable line; only line 0 is capable
`define DIO_AUX_CAPABLE 4'h1
// circuit type code per line, two bits each
`define DIO_CIRCUIT_CODES 8'h55

`endif

// ===== src/dio_pkg.sv
// types shared by the digital io control block
`default_nettype none
package dio_pkg;
    typedef enum logic [4:0] {
        DIO_SRC_OFF = 5'h00,
        DIO_SRC_LINE0 = 5'h01,
        DIO_SRC_LINE1 = 5'h02,
        DIO_SRC_LINE2 = 5'h03,
        DIO_SRC_LINE3 = 5'h04,
        DIO_SRC_USER0 = 5'h05,
        DIO_SRC_USER1 = 5'h06,
        DIO_SRC_USER2 = 5'h07,
        DIO_SRC_USER3 = 5'h08,
        DIO_SRC_CNT0 = 5'h09,
        DIO_SRC_CNT1 = 5'h0a,
        DIO_SRC_LOGIC0 = 5'h0b,
        DIO_SRC_LOGIC1 = 5'h0c,
        DIO_SRC_EXPOSE = 5'h0d,
        DIO_SRC_TRIGWAIT = 5'h0e,
        DIO_SRC_PPS = 5'h0f,
        DIO_SRC_SERIAL = 5'h10
    } dio_src_e;

    typedef enum logic [1:0] {
        DIO_CT_TRISTATE = 2'h0,
        DIO_CT_OPTO = 2'h1,
        DIO_CT_OPENDRAIN = 2'h2
    } dio_circuit_e;

    typedef enum logic [2:0] {
        DIO_DG_IDLE = 3'b001,
        DIO_DG_WAIT = 3'b010,
        DIO_DG_HOLD = 3'b100
    } dio_filt_e;
endpackage : dio_pkg
`default_nettype wire

// ===== src/dio_line_filter.sv
// deglitch then debounce filter for one input line
`default_nettype none
`include "dio_defs.svh"
module dio_line_filter
    import dio_pkg::*;
#(
    parameter int SPAN_W = 16,
    parameter int CNT_W = 26
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // raw synchronised level and widths in microseconds
    input wire logic rawLevel,
    input wire logic [SPAN_W-1:0] glitchSpanUs,
    input wire logic [SPAN_W-1:0] bounceSpanUs,
    // filtered level
    output logic cleanLevel
);
    // ---------------------------------------------
    // width conversion
    // ---------------------------------------------
    logic [CNT_W-1:0] glitchCycles;
    logic [CNT_W-1:0] bounceCycles;
    assign glitchCycles = CNT_W'(glitchSpanUs * `DIO_CLK_MHZ);
    assign bounceCycles = CNT_W'(bounceSpanUs * `DIO_CLK_MHZ);

    // ---------------------------------------------
    // state
    // ---------------------------------------------
    logic glitchOut_r, glitchOut_nxt;
    logic [CNT_W-1:0] glitchCnt_r, glitchCnt_nxt;
    logic bounceOut_r, bounceOut_nxt;
    logic [CNT_W-1:0] bounceCnt_r, bounceCnt_nxt;
    dio_filt_e bounceSt_r, bounceSt_nxt;

    always_comb begin
        glitchOut_nxt = glitchOut_r;
        glitchCnt_nxt = glitchCnt_r;
        if (rawLevel == glitchOut_r) begin
            glitchCnt_nxt = '0;
        end else if (glitchCnt_r + 1'b1 >= glitchCycles) begin
            glitchOut_nxt = rawLevel;
            glitchCnt_nxt = '0;
        end else begin
            glitchCnt_nxt = glitchCnt_r + 1'b1;
        end
        bounceOut_nxt = bounceOut_r;
        bounceCnt_nxt = bounceCnt_r;
        bounceSt_nxt = bounceSt_r;
        case (bounceSt_r)
            DIO_DG_IDLE: begin
                if (glitchOut_r != bounceOut_r) begin
                    bounceOut_nxt = glitchOut_r;
                    bounceCnt_nxt = '0;
                    bounceSt_nxt = DIO_DG_HOLD;
                end
            end
            DIO_DG_HOLD: begin
                if (bounceCnt_r + 1'b1 >= bounceCycles) begin
                    bounceSt_nxt = DIO_DG_IDLE;
                end else begin
                    bounceCnt_nxt = bounceCnt_r + 1'b1;
                end
            end
            default: begin
                bounceSt_nxt = DIO_DG_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            glitchOut_r <= 1'b1;
            glitchCnt_r <= '0;
            bounceOut_r <= 1'b1;
            bounceCnt_r <= '0;
            bounceSt_r <= DIO_DG_IDLE;
        end else begin
            glitchOut_r <= glitchOut_nxt;
            glitchCnt_r <= glitchCnt_nxt;
            bounceOut_r <= bounceOut_nxt;
            bounceCnt_r <= bounceCnt_nxt;
            bounceSt_r <= bounceSt_nxt;
        end
    end

    assign cleanLevel = bounceOut_r;
endmodule // dio_line_filter
`default_nettype wire

// ===== verification/dio_pin_model.sv
// external circuits on the four connector lines, with pull-ups
`default_nettype none
module dio_pin_model (
    // device side, open drain
    input wire logic [3:0] lineOut,
    input wire logic [3:0] lineOeN,
    // external switches that pull a line low
    input wire logic [3:0] extLow,
    // resolved wire levels
    output logic [3:0] pinWire
);
    timeunit 1ns;
    timeprecision 1ps;
    // pull-up wins unless the device or a switch sinks the line
    assign pinWire = ~((~lineOeN & ~lineOut) | extLow);
endmodule // dio_pin_model
`default_nettype wire

// ===== verification/dio_ctrl_sva.sv
// port assertions for the digital io control block
`default_nettype none
`include "dio_defs.svh"
module dio_ctrl_chk #(
    parameter int NLINE = 4,
    parameter int NUSER = 4
) (
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWrData,
    input wire logic regWrStb,
    input wire logic regRdStb,
    input wire logic [31:0] regRdData,
    // lines and user bank
    input wire logic [NLINE-1:0] lineOut,
    input wire logic [NLINE-1:0] lineOeN,
    input wire logic [NLINE-1:0] auxRailOn,
    input wire logic [NUSER-1:0] swBits
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] CT = `DIO_CIRCUIT_CODES;
    localparam logic [3:0] AUX = `DIO_AUX_CAPABLE;
    logic [NUSER-1:0] wrLow;
    assign wrLow = regWrData[NUSER-1:0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    sequence sRd(logic [7:0] a);
        regRdStb && regAddr == a;
    endsequence
    sequence sWr(logic [7:0] a);
        regWrStb && regAddr == a;
    endsequence
    AST_RD_IDLE: assert property (!$past(regRdStb) |-> regRdData == 0)
        else $error("read data not zero outside a read");
    AST_RST_STATE: assert property (disable iff (1'b0) sys_rst |=>
        lineOeN == '1 && auxRailOn == '0 && swBits == '0)
        else $error("state after reset wrong");
    AST_OPEN_DRAIN: assert property (lineOut == '0)
        else $error("line drives high");
    AST_AUX_ONLY: assert property ((auxRailOn & ~AUX) == '0)
        else $error("aux rail on an incapable line");
    AST_SW_PACKED_WR: assert property (sWr(8'h30) |=>
        swBits == $past(wrLow))
        else $error("packed user write lost");
    AST_SW_HOLD: assert property (!(regWrStb && (regAddr == 8'h2c ||
        regAddr == 8'h30)) |=> $stable(swBits))
        else $error("user bits moved without a write");
    AST_SW_PACKED_RD: assert property (sRd(8'h30) |=>
        regRdData[NUSER-1:0] == $past(swBits) && regRdData[31:NUSER] == 0)
        else $error("packed user read wrong");
    AST_CT_RD: assert property (sRd(8'h24) |=>
        regRdData == {30'h0, CT[1:0]})
        else $error("circuit type read wrong");
endmodule // dio_ctrl_chk
bind dio_ctrl dio_ctrl_chk #(.NLINE(NLINE), .NUSER(NUSER)) chk (
    .mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
    .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
    .regRdData(regRdData), .lineOut(lineOut), .lineOeN(lineOeN),
    .auxRailOn(auxRailOn), .swBits(swBits));
`default_nettype wire

// ===== verification/tb.sv
// self-checking bench for the digital io control block
`default_nettype none
module tb
    import dio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk, sys_rst, regWrStb, regRdStb;
    logic [7:0] regAddr, srcIn;
    logic [31:0] regWrData, regRdData;
    logic [3:0] lineIn, lineOut, lineOeN, auxRailOn, swBits, extLow;
    int mismatches, n_checks;
    dio_ctrl uut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb),
        .regRdData(regRdData), .lineIn(lineIn), .lineOut(lineOut),
        .lineOeN(lineOeN), .auxRailOn(auxRailOn),
        .counterActive(srcIn[1:0]), .logicBlockOut(srcIn[3:2]),
        .exposureActive(srcIn[4]), .frameTriggerWait(srcIn[5]),
        .ppsSignal(srcIn[6]), .serialTx(srcIn[7]), .swBits(swBits));
    dio_pin_model pins (.lineOut(lineOut), .lineOeN(lineOeN),
        .extLow(extLow), .pinWire(lineIn));
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    // ------------------------------
    // shared tasks
    // ------------------------------
    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge mclk);
        regWrStb <= 1'b1;
        regAddr <= a;
        regWrData <= v;
        @(posedge mclk);
        regWrStb <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge mclk);
        regRdStb <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdStb <= 1'b0;
        #1;
        chk(regRdData, e);
    endtask
    task automatic ext(input logic [3:0] v);
        @(posedge mclk);
        extLow <= v;
    endtask
    // ------------------------------
    // scenarios
    // ------------------------------
    // state after reset
    task automatic t_reset();
        chk({20'h0, swBits, auxRailOn, lineOeN}, 32'hf);
        rd(8'h04, 32'h0);
        rd(8'h0c, 32'h0);
        rd(8'h1c, 32'h0);
        rd(8'h20, 32'h0);
        rd(8'h14, 32'hf);
        rd(8'h24, {30'h0, DIO_CT_OPTO});
        $display("reset test done");
    endtask
    task automatic t_user();
        for (int i = 0; i < 4; i++) begin
            wr(8'h28, i);
            wr(8'h2c, 32'h1);
            cyc(1);
            chk({28'h0, swBits}, (32'h2 << i) - 1);
        end
        wr(8'h30, 32'ha);
        rd(8'h30, 32'ha);
        wr(8'h28, 32'h2);
        rd(8'h2c, 32'h0);
        wr(8'h2c, 32'h1);
        rd(8'h30, 32'he);
        wr(8'h28, 32'h3);
        wr(8'h2c, 32'h0);
        rd(8'h30, 32'h6);
        $display("user bank test done");
    endtask
    // one width per line and filter kind
    task automatic t_spans();
        for (int p = 0; p < 3; p++) begin
            for (int l = 0; l < 4; l++) begin
                for (int k = 0; k < 2; k++) begin
                    wr(8'h00, l);
                    wr(8'h18, k);
                    if (p == 1) rd(8'h1c, 16 * l + k + 3);
                    else wr(8'h1c, (p == 0) ? 16 * l + k + 3 : 0);
                end
            end
        end
        $display("filter width test done");
    endtask
    task automatic t_drive();
        wr(8'h00, 32'h1);
        wr(8'h30, 32'h5);
        wr(8'h20, DIO_SRC_USER1);
        cyc(4);
        chk({28'h0, lineOeN}, 32'hf);
        wr(8'h04, 32'h1);
        for (int u = 0; u < 4; u++) begin
            wr(8'h20, DIO_SRC_USER0 + u);
            cyc(4);
            chk({31'h0, lineOeN[1]}, (32'h5 >> u) & 1);
            rd(8'h10, (32'h5 >> u) & 1);
        end
        wr(8'h0c, 32'h1);
        cyc(4);
        chk({31'h0, lineOeN[1]}, 32'h1);
        wr(8'h0c, 32'h0);
        for (int k = 0; k < 8; k++) begin
            wr(8'h20, DIO_SRC_CNT0 + k);
            srcIn <= ~(8'h1 << k);
            cyc(4);
            chk({31'h0, lineOeN[1]}, 32'h0);
            @(posedge mclk);
            srcIn <= 8'h1 << k;
            cyc(4);
            chk({31'h0, lineOeN[1]}, 32'h1);
        end
        for (int j = 0; j < 4; j += (j == 0) ? 2 : 1) begin
            wr(8'h20, DIO_SRC_LINE0 + j);
            ext(4'h1 << j);
            cyc(12);
            chk({31'h0, lineOeN[1]}, 32'h0);
            ext(4'h0);
            cyc(12);
            chk({31'h0, lineOeN[1]}, 32'h1);
        end
        wr(8'h04, 32'h0);
        cyc(4);
        chk({28'h0, lineOeN}, 32'hf);
        $display("drive test done");
    endtask
    task automatic t_input();
        ext(4'h4);
        cyc(10);
        rd(8'h14, 32'hb);
        wr(8'h00, 32'h2);
        rd(8'h10, 32'h0);
        wr(8'h0c, 32'h1);
        cyc(2);
        rd(8'h10, 32'h1);
        rd(8'h14, 32'hf);
        wr(8'h0c, 32'h0);
        ext(4'h0);
        $display("input test done");
    endtask
    // filters on line 3, 1 us = 250 cycles
    task automatic t_filter();
        wr(8'h00, 32'h3);
        wr(8'h18, 32'h0);
        wr(8'h1c, 32'h1);
        ext(4'h8);
        cyc(226);
        rd(8'h14, 32'hf);
        cyc(40);
        rd(8'h14, 32'h7);
        wr(8'h1c, 32'h0);
        wr(8'h18, 32'h1);
        wr(8'h1c, 32'h1);
        ext(4'h0);
        cyc(12);
        rd(8'h14, 32'hf);
        ext(4'h8);
        cyc(50);
        rd(8'h14, 32'hf);
        cyc(250);
        rd(8'h14, 32'h7);
        wr(8'h1c, 32'h0);
        ext(4'h0);
        $display("filter test done");
    endtask
    // aux rail, read-only and unmapped places
    task automatic t_aux();
        wr(8'h00, 32'h0);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h1);
        chk({28'h0, auxRailOn}, 32'h1);
        wr(8'h00, 32'h2);
        wr(8'h08, 32'h1);
        rd(8'h08, 32'h0);
        wr(8'h24, 32'h3);
        rd(8'h24, {30'h0, DIO_CT_OPTO});
        wr(8'h40, 32'h5);
        rd(8'h40, 32'h0);
        $display("aux and read-only test done");
    endtask
    initial begin
        sys_rst = 1'b1;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        regAddr = 8'h00;
        regWrData = 32'h0;
        extLow = 4'h0;
        srcIn = 8'h00;
        mismatches = 0;
        n_checks = 0;
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        cyc(8);
        t_reset();
        t_user();
        t_spans();
        t_drive();
        t_input();
        t_filter();
        t_aux();
        results();
    end
    // watchdog: the run needs about 1100 cycles
    initial begin
        #100000;
        mismatches++;
        results();
    end
endmodule // tb
`default_nettype wire
